// ---- dv/tb.sv ----
`timescale 1ns/100ps
module tb;
  import vac_pkg::*;
  localparam int ENC_T = 2000;

  logic              clk, reset, hsel, hwrite, hready, hreadyout;
  logic              encode_pulse, display_holdoff, record_cmd, external_selection_position;
  logic              vfc_pulse, gain_x10, atten_1000v, overload_lamp, sample_start;
  logic [31:0]       haddr, hwdata, hrdata, rd;
  logic [1:0]        htrans, hresp;
  logic [2:0]        hsize;
  logic [NRANGE-1:0] range_sel;
  logic [7:0]        period;
  int                miscompares, checks_done;
  int                cycles = 0;

  assign hready = hreadyout;

  vac_autorange #(.WIN_CYC(200), .SPC_CYC(1000), .OS_CYC(50), .ENC_CYC(ENC_T)) vac_autorange_i (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .vfc_pulse(vfc_pulse), .encode_pulse(encode_pulse),
    .display_holdoff(display_holdoff), .record_cmd(record_cmd),
    .external_selection_position(external_selection_position), .range_sel(range_sel),
    .gain_x10(gain_x10), .atten_1000v(atten_1000v), .overload_lamp(overload_lamp),
    .sample_start(sample_start));

  vac_vfc_model vac_vfc_model_i (.clk(clk), .reset(reset), .period(period), .vfc_pulse(vfc_pulse));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Single word transfer; read data lands in rd
  task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    hsel   <= 1'b1;
    haddr  <= {24'h0, addr};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= data;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : ahb

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic encode();
    encode_pulse <= 1'b1;
    tick(4);
    encode_pulse <= 1'b0;
  endtask : encode

  task automatic wait_start();
    for (int i = 0; i < 8000 && sample_start !== 1'b1; i++) @(posedge clk);
    chk(32'(sample_start), 32'h1);
  endtask : wait_start

  task automatic wait_chg(input logic [NRANGE-1:0] old);
    for (int i = 0; i < 3000 && range_sel === old; i++) @(posedge clk);
  endtask : wait_chg

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    encode_pulse = 1'b0;
    display_holdoff = 1'b0;
    record_cmd = 1'b0;
    external_selection_position = 1'b0;
    period = 8'h00;
    miscompares = 0;
    checks_done = 0;
    tick(4);
    reset <= 1'b0;
    tick(2);
    chk(32'(range_sel), 32'h20);
    ahb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'(CTRL_RESET));
    ahb(1'b1, 8'h40, 32'hffff_ffff);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    // Low input rate, no encode yet: range must hold
    ahb(1'b1, CTRL_OFS, 32'h1);
    tick(3000);
    chk(32'(range_sel), 32'h20);
    encode();
    wait_start();
    chk(32'(range_sel), 32'h04);
    ahb(1'b0, RANGE_OFS, 32'h0);
    chk(rd, 32'h2);
    // Amplifier present, auto from the pin
    external_selection_position <= 1'b1;
    ahb(1'b1, CTRL_OFS, 32'h2);
    encode();
    wait_start();
    chk(32'(range_sel), 32'h01);
    chk(32'(gain_x10), 32'h1);
    // Mid rate: no change requested
    period <= 8'd20;
    ahb(1'b1, RANGE_OFS, 32'h2);
    tick(600);
    encode();
    wait_start();
    chk(32'(range_sel), 32'h04);
    // High rate after encode: one step up, then low pulses blocked
    ahb(1'b1, RANGE_OFS, 32'h0);
    period <= 8'd4;
    encode();
    wait_chg(6'h01);
    chk(32'(range_sel), 32'h02);
    period <= 8'h00;
    ahb(1'b0, STATUS_OFS, 32'h0);
    chk(32'(rd[0]), 32'h1);
    wait_start();
    chk(32'(range_sel), 32'h02);
    // Record held: no downranging
    ahb(1'b1, RANGE_OFS, 32'h3);
    record_cmd <= 1'b1;
    encode();
    tick(4000);
    chk(32'(range_sel), 32'h08);
    // Display period overload jumps to the top range
    record_cmd <= 1'b0;
    ahb(1'b1, RANGE_OFS, 32'h2);
    display_holdoff <= 1'b1;
    period <= 8'd4;
    tick(2);
    wait_chg(6'h04);
    chk(32'(range_sel), 32'h20);
    chk(32'(atten_1000v), 32'h1);
    chk(32'(overload_lamp), 32'h0);
    ahb(1'b0, STATUS_OFS, 32'h0);
    chk(32'(rd[1]), 32'h1);
    external_selection_position <= 1'b0;
    ahb(1'b1, CTRL_OFS, 32'h0);
    tick(10);
    chk(32'(overload_lamp), 32'h1);
    print_verdict();
  end
endmodule : tb

// ---- dv/vac_autorange_properties.sv ----
`timescale 1ns/100ps
module vac_autorange_properties
  import vac_pkg::*;
#(
  parameter int ENC_CYC = ENC_DELAY_CYC
) (
  input wire logic              clk,                         // System clock
  input wire logic              reset,                       // Async reset
  input wire logic              hsel,                        // AHB select
  input wire logic [1:0]        htrans,                      // AHB transfer type
  input wire logic              hwrite,                      // AHB write
  input wire logic              hready,                      // AHB ready in
  input wire logic              hreadyout,                   // AHB ready out
  input wire logic [1:0]        hresp,                       // AHB response
  input wire logic              display_holdoff,             // Display period
  input wire logic              record_cmd,                  // Sample period
  input wire logic              external_selection_position, // Auto select
  input wire logic [NRANGE-1:0] range_sel,                   // Range selects
  input wire logic              gain_x10,                    // Gain x10
  input wire logic              atten_1000v,                 // Attenuator 1000 V
  input wire logic              overload_lamp,               // Overload lamp
  input wire logic              sample_start                 // Encode delay done
);
  logic [5:0]        wr_hist;
  logic [NRANGE-1:0] sel_q;
  logic [31:0]       since_chg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Recent bus writes may load the range directly, so step checks skip them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_hist   <= 6'h00;
      sel_q     <= '0;
      since_chg <= 32'h0;
    end else begin
      wr_hist   <= {wr_hist[4:0], hsel && hready && hwrite && htrans == HTRANS_NONSEQ};
      sel_q     <= range_sel;
      since_chg <= (range_sel != sel_q) ? 32'h0 : since_chg + 32'h1;
    end
  end

  sequence quiet_bus_s;
    wr_hist == 6'h00;
  endsequence
  sequence holdoff_s;
    display_holdoff [*6];
  endsequence
  sequence record_s;
    record_cmd [*6];
  endsequence

  bus_answer_a: assert property (hsel && hready && htrans == HTRANS_NONSEQ |=> hreadyout && hresp == HRESP_OKAY)
    else $error("bus transfer not answered at once");
  sel_onehot_a: assert property (!$past(reset) |-> $onehot(range_sel))
    else $error("range select not one-hot");
  gain_match_a: assert property (!$past(reset) |-> gain_x10 == range_sel[0])
    else $error("gain does not follow range");
  atten_match_a: assert property (!$past(reset) |-> atten_1000v == range_sel[5])
    else $error("attenuator does not follow range");
  lamp_dark_a: assert property (external_selection_position [*6] |-> !overload_lamp)
    else $error("overload lamp lit while auto");
  single_step_a: assert property (!$past(reset) && wr_hist == 6'h00 && $changed(range_sel) && !range_sel[5]
    |-> range_sel == ($past(range_sel) << 1) || range_sel == ($past(range_sel) >> 1))
    else $error("range moved more than one step");
  holdoff_keep_a: assert property (holdoff_s ##0 quiet_bus_s |=> range_sel >= $past(range_sel))
    else $error("range lowered in display period");
  record_keep_a: assert property (record_s ##0 quiet_bus_s |=> range_sel >= $past(range_sel))
    else $error("range lowered in sample period");
  start_delay_a: assert property (sample_start |-> since_chg >= ENC_CYC - 4)
    else $error("sample start too soon after range change");
  start_pulse_a: assert property (sample_start |=> !sample_start)
    else $error("sample start longer than one cycle");
endmodule : vac_autorange_properties

bind vac_autorange vac_autorange_properties #(.ENC_CYC(ENC_CYC)) vac_autorange_properties_i (
  .clk(clk), .reset(reset), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .display_holdoff(display_holdoff), .record_cmd(record_cmd),
  .external_selection_position(external_selection_position), .range_sel(range_sel), .gain_x10(gain_x10),
  .atten_1000v(atten_1000v), .overload_lamp(overload_lamp), .sample_start(sample_start));

// ---- dv/vac_vfc_model.sv ----
`timescale 1ns/100ps
module vac_vfc_model (
  input  wire logic       clk,       // System clock
  input  wire logic       reset,     // Async reset
  input  wire logic [7:0] period,    // Cycles between pulses, 0 is silent
  output logic            vfc_pulse  // Converter pulse train
);
  logic [7:0] cnt_reg;

  // One-cycle pulse each period; a zero input rate means no edges at all
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg   <= 8'h00;
      vfc_pulse <= 1'b0;
    end else begin
      cnt_reg   <= (cnt_reg + 8'h01 >= period) ? 8'h00 : cnt_reg + 8'h01;
      vfc_pulse <= (period != 8'h00) && (cnt_reg == 8'h00);
    end
  end
endmodule : vac_vfc_model

// ---- hw/vac_autorange.sv ----
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
module vac_autorange
  import vac_pkg::*;
#(
  parameter int WIN_CYC = WINDOW_CYC,
  parameter int SPC_CYC = SPACING_CYC,
  parameter int OS_CYC  = ONESHOT_CYC,
  parameter int ENC_CYC = ENC_DELAY_CYC
) (
  input  wire logic              clk,                         // System clock
  input  wire logic              reset,                       // Async reset
  input  wire logic              hsel,                        // AHB select
  input  wire logic [31:0]       haddr,                       // AHB address
  input  wire logic [1:0]        htrans,                      // AHB transfer type
  input  wire logic              hwrite,                      // AHB write
  input  wire logic [2:0]        hsize,                       // AHB size
  input  wire logic [31:0]       hwdata,                      // AHB write data
  input  wire logic              hready,                      // AHB ready in
  output logic                   hreadyout,                   // AHB ready out
  output logic [1:0]             hresp,                       // AHB response
  output logic [31:0]            hrdata,                      // AHB read data
  input  wire logic              vfc_pulse,                   // Converter pulse pin
  input  wire logic              encode_pulse,                // Encode reset pin
  input  wire logic              display_holdoff,             // Display period pin
  input  wire logic              record_cmd,                  // Sample period pin
  input  wire logic              external_selection_position, // Auto select pin
  output logic [NRANGE-1:0]      range_sel,                   // Range select lines
  output logic                   gain_x10,                    // Amplifier gain x10
  output logic                   atten_1000v,                 // Attenuator at 1000 V
  output logic                   overload_lamp,               // Overload indicator
  output logic                   sample_start                 // Encode delay done
);

  localparam int NPIN = 5;
  localparam int PV   = 0;
  localparam int PE   = 1;
  localparam int PH   = 2;
  localparam int PR   = 3;
  localparam int PX   = 4;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_reg;
  logic [NPIN-1:0] s2_reg;
  logic [NPIN-1:0] s3_reg;

  logic            vfc_rise;
  logic            enc_rise;
  logic            rec_rise;
  logic            holdoff;
  logic            rec_on;
  logic            auto_active;

  logic            hi_pulse;
  logic            lo_pulse;
  logic            hi_d_reg;
  logic            lo_d_reg;
  logic            hi_rise;
  logic            lo_rise;
  logic            hi_gate;
  logic            lo_gate;
  logic            ovl_hit;
  logic            step_fire;
  logic            os_busy;

  logic [1:0]      ctrl_reg;
  logic [2:0]      range_reg;
  logic [2:0]      floor_code;
  logic            up_reg;
  logic            overload_reg;
  logic            enc_delay_reg;
  logic [CNT_W-1:0] enc_cnt_reg;

  logic            wr_pend_reg;
  logic [7:0]      wr_addr_reg;
  logic            addr_ok;
  logic            man_load;
  logic [31:0]     rd_next;
  vac_status_t     status;
  vac_range_out_t  rout_next;

  assign pin_raw = {external_selection_position, record_cmd, display_holdoff, encode_pulse, vfc_pulse};

  // Two-stage synchronisers plus an edge stage
  generate
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          s1_reg[i] <= 1'b0;
          s2_reg[i] <= 1'b0;
          s3_reg[i] <= 1'b0;
        end else begin
          s1_reg[i] <= pin_raw[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
        end
      end
    end
  endgenerate

  assign vfc_rise    = s2_reg[PV] & ~s3_reg[PV];
  assign enc_rise    = s2_reg[PE] & ~s3_reg[PE];
  assign rec_rise    = s2_reg[PR] & ~s3_reg[PR];
  assign holdoff     = s2_reg[PH];
  assign rec_on      = s2_reg[PR];
  assign auto_active = ctrl_reg[CTRL_AUTO_BIT] | s2_reg[PX];

  vac_rate_detect #(
    .HIGH    (1'b1),
    .THR     (HIGH_THR),
    .WIN_CYC (WIN_CYC),
    .SPC_CYC (SPC_CYC),
    .PW_CYC  (PULSE_CYC)
  ) u_high (
    .clk       (clk),
    .reset     (reset),
    .edge_seen (vfc_rise),
    .pulse_out (hi_pulse)
  );

  vac_rate_detect #(
    .HIGH    (1'b0),
    .THR     (LOW_THR),
    .WIN_CYC (WIN_CYC),
    .SPC_CYC (SPC_CYC),
    .PW_CYC  (PULSE_CYC)
  ) u_low (
    .clk       (clk),
    .reset     (reset),
    .edge_seen (vfc_rise),
    .pulse_out (lo_pulse)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hi_d_reg <= 1'b0;
      lo_d_reg <= 1'b0;
    end else begin
      hi_d_reg <= hi_pulse;
      lo_d_reg <= lo_pulse;
    end
  end

  assign hi_rise = hi_pulse & ~hi_d_reg;
  assign lo_rise = lo_pulse & ~lo_d_reg;

  // No amplifier: lowest auto range is 1 V
  assign floor_code = ctrl_reg[CTRL_AMP_BIT] ? RANGE_10MV : RANGE_1V;

  // Range gates
  assign hi_gate = hi_rise & auto_active & ~holdoff & (enc_delay_reg | rec_on)
                   & (range_reg < RANGE_1000V);
  assign lo_gate = lo_rise & auto_active & enc_delay_reg & ~up_reg & ~rec_on & ~holdoff
                   & (range_reg > floor_code);
  assign ovl_hit = hi_rise & (holdoff | ~auto_active);

  vac_count_oneshot #(
    .DLY_CYC (OS_CYC)
  ) u_oneshot (
    .clk   (clk),
    .reset (reset),
    .trig  (hi_gate | lo_gate),
    .fire  (step_fire),
    .busy  (os_busy)
  );

  // Up/down state: encode clears to down, gated high pulse sets up and wins over encode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      up_reg <= 1'b0;
    end else if (hi_gate) begin
      up_reg <= 1'b1;
    end else if (enc_rise) begin
      up_reg <= 1'b0;
    end
  end

  // Reversible range counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      range_reg <= RANGE_1000V;
    end else if (man_load) begin
      range_reg <= hwdata[2:0];
    end else if (ovl_hit) begin
      range_reg <= RANGE_1000V;
    end else if (step_fire) begin
      if (up_reg && range_reg < RANGE_1000V) begin
        range_reg <= range_reg + 3'h1;
      end else if (!up_reg && range_reg > floor_code) begin
        range_reg <= range_reg - 3'h1;
      end
    end
  end

  // Overload state; set wins over encode clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      overload_reg <= 1'b0;
    end else if (ovl_hit) begin
      overload_reg <= 1'b1;
    end else if (enc_rise) begin
      overload_reg <= 1'b0;
    end
  end

  // Encode delay restarts after a range step that fires while the delay is running
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enc_delay_reg <= 1'b0;
      enc_cnt_reg   <= '0;
      sample_start  <= 1'b0;
    end else begin
      sample_start <= 1'b0;
      if (enc_rise || (enc_delay_reg && step_fire)) begin
        enc_delay_reg <= 1'b1;
        enc_cnt_reg   <= CNT_W'(ENC_CYC);
      end else if (rec_rise) begin
        enc_delay_reg <= 1'b0;
      end else if (enc_delay_reg) begin
        if (enc_cnt_reg == CNT_W'(1)) begin
          enc_delay_reg <= 1'b0;
          sample_start  <= 1'b1;
        end else if (!os_busy) begin
          enc_cnt_reg <= enc_cnt_reg - CNT_W'(1);
        end
      end
    end
  end

  // Range decode to program connector
  always_comb begin
    rout_next             = '0;
    rout_next.sel[range_reg] = 1'b1;
    rout_next.gain_x10    = (range_reg == RANGE_10MV);
    rout_next.atten_1000v = (range_reg == RANGE_1000V);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      range_sel     <= '0;
      gain_x10      <= 1'b0;
      atten_1000v   <= 1'b0;
      overload_lamp <= 1'b0;
    end else begin
      range_sel     <= rout_next.sel;
      gain_x10      <= rout_next.gain_x10;
      atten_1000v   <= rout_next.atten_1000v;
      overload_lamp <= overload_reg & ~auto_active;
    end
  end

  // AHB-Lite slave, zero wait states
  assign addr_ok  = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign man_load = wr_pend_reg & (wr_addr_reg == RANGE_OFS);

  assign status.enc_delay   = enc_delay_reg;
  assign status.holdoff     = holdoff;
  assign status.auto_active = auto_active;
  assign status.overload    = overload_reg;
  assign status.count_up    = up_reg;

  always_comb begin
    rd_next = '0;
    unique case (haddr[7:0])
      CTRL_OFS:   rd_next[1:0] = ctrl_reg;
      RANGE_OFS:  rd_next[2:0] = range_reg;
      STATUS_OFS: rd_next[4:0] = status;
      default:    rd_next      = '0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata      <= '0;
    end else begin
      wr_pend_reg <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr_reg <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= rd_next;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_pend_reg && wr_addr_reg == CTRL_OFS) begin
      ctrl_reg <= hwdata[1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b0;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

endmodule : vac_autorange

// ---- hw/vac_count_oneshot.sv ----
`timescale 1ns/100ps
module vac_count_oneshot
  import vac_pkg::*;
#(
  parameter int DLY_CYC = ONESHOT_CYC
) (
  input  wire logic clk,    // System clock
  input  wire logic reset,  // Async reset
  input  wire logic trig,   // Gated range pulse
  output logic      fire,   // Delayed counter step
  output logic      busy    // Unstable state
);

  logic [CNT_W-1:0] cnt_reg;

  // Retrigger while busy is ignored
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
      busy    <= 1'b0;
      fire    <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (busy) begin
        cnt_reg <= cnt_reg - CNT_W'(1);
        if (cnt_reg == CNT_W'(1)) begin
          busy <= 1'b0;
          fire <= 1'b1;
        end
      end else if (trig) begin
        busy    <= 1'b1;
        cnt_reg <= CNT_W'(DLY_CYC);
      end
    end
  end

endmodule : vac_count_oneshot

// ---- hw/vac_fix_note.sv ----
`timescale 1ns/100ps

// ---- hw/vac_pkg.sv ----
package vac_pkg;

  localparam int CLK_MHZ      = 125;
  localparam int CNT_W        = 22;

  // Detector timing
  localparam int PULSE_NS     = 2000;
  localparam int PULSE_CYC    = PULSE_NS * CLK_MHZ / 1000;
  localparam int SPACING_US   = 5500;
  localparam int SPACING_CYC  = SPACING_US * CLK_MHZ;
  localparam int WINDOW_US    = 100;
  localparam int WINDOW_CYC   = WINDOW_US * CLK_MHZ;
  localparam int HIGH_KHZ     = 310;
  localparam int LOW_KHZ      = 30;
  localparam int HIGH_THR     = HIGH_KHZ * WINDOW_US / 1000;
  localparam int LOW_THR      = LOW_KHZ * WINDOW_US / 1000;

  // Range step and encode delay timing
  localparam int ONESHOT_US   = 500;
  localparam int ONESHOT_CYC  = ONESHOT_US * CLK_MHZ;
  localparam int ENC_DELAY_US = 9700;
  localparam int ENC_DELAY_CYC = ENC_DELAY_US * CLK_MHZ;

  // Range codes, 10 mV up to 1000 V
  localparam logic [2:0] RANGE_10MV  = 3'h0;
  localparam logic [2:0] RANGE_1V    = 3'h2;
  localparam logic [2:0] RANGE_1000V = 3'h5;
  localparam int         NRANGE      = 6;

  // Register map
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] RANGE_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam int CTRL_AUTO_BIT   = 0;
  localparam int CTRL_AMP_BIT    = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY    = 2'h0;

  typedef struct packed {
    logic [NRANGE-1:0] sel;
    logic              gain_x10;
    logic              atten_1000v;
  } vac_range_out_t;

  typedef struct packed {
    logic       enc_delay;
    logic       holdoff;
    logic       auto_active;
    logic       overload;
    logic       count_up;
  } vac_status_t;

endpackage : vac_pkg

// ---- hw/vac_rate_detect.sv ----
`timescale 1ns/100ps
module vac_rate_detect
  import vac_pkg::*;
#(
  parameter bit HIGH    = 1'b1,
  parameter int THR     = HIGH_THR,
  parameter int WIN_CYC = WINDOW_CYC,
  parameter int SPC_CYC = SPACING_CYC,
  parameter int PW_CYC  = PULSE_CYC
) (
  input  wire logic clk,        // System clock
  input  wire logic reset,      // Async reset
  input  wire logic edge_seen,  // One converter pulse seen
  output logic      pulse_out   // Detector pulse train
);

  logic [CNT_W-1:0] win_reg;
  logic [CNT_W-1:0] edges_reg;
  logic [CNT_W-1:0] spc_reg;
  logic [CNT_W-1:0] pw_reg;
  logic             cond_reg;

  // Rate measured over a fixed window
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      win_reg   <= '0;
      edges_reg <= '0;
      cond_reg  <= 1'b0;
    end else if (win_reg == '0) begin
      win_reg   <= CNT_W'(WIN_CYC - 1);
      edges_reg <= '0;
      cond_reg  <= HIGH ? (edges_reg >= CNT_W'(THR)) : (edges_reg < CNT_W'(THR));
    end else begin
      win_reg <= win_reg - CNT_W'(1);
      if (edge_seen) begin
        edges_reg <= edges_reg + CNT_W'(1);
      end
    end
  end

  // Pulse train while condition persists
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      spc_reg   <= '0;
      pw_reg    <= '0;
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= (pw_reg != '0);
      if (pw_reg != '0) begin
        pw_reg <= pw_reg - CNT_W'(1);
      end
      if (spc_reg != '0) begin
        spc_reg <= spc_reg - CNT_W'(1);
      end else if (cond_reg && pw_reg == '0) begin
        pw_reg  <= CNT_W'(PW_CYC);
        spc_reg <= CNT_W'(SPC_CYC);
      end
    end
  end

endmodule : vac_rate_detect
